// >>> verilog/atcb_top.v
// Notes on behaviour
// [RULE1] The offset trim is an 8-bit read/write byte, reset to zero, for the shared channels.
// [RULE2] The first coefficient byte holds order-zero bits 7 to 0, reads only, resets to zero.
// [RULE3] The second byte holds order-zero bits 14 to 8 in its bits 6 to 0.
// [RULE4] The second byte holds order-one bit 0 in its bit 7.
// [RULE5] The third byte holds order-one bits 8 to 1, reads only, resets to zero.
// [RULE6] The fourth byte holds order-one bits 13 to 9 in its bits 4 to 0.
// [RULE7] The fourth byte holds order-two bits 2 to 0 in its bits 7 to 5.
// [RULE8] The fifth byte holds order-two bits 10 to 3, reads only, resets to zero.
// [RULE9] The sixth byte holds order-two bits 13 to 11 in its low three bits.
// [RULE10] The gain trim is an 8-bit read/write byte, reset to zero, for the same channels.
// [RULE11] Reads have no side effect and writes to coefficient bytes change nothing; the code sets the status read-only-write flag on such a write.
`timescale 1ns/1ps
`default_nettype none
`include "atcb_defines.vh"

module atcb_top (
    input wire sys_clk,
    input wire rstn,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [`ATCB_ADR_W-1:0] adr_i,
    input wire [`ATCB_DAT_W-1:0] dat_i,
    input wire [`ATCB_SEL_W-1:0] sel_i,
    output wire [`ATCB_DAT_W-1:0] dat_o,
    output wire ack_o,
    input wire coefLoad,
    input wire [`ATCB_TC0_W-1:0] coefOrder0In,
    input wire [`ATCB_TC1_W-1:0] coefOrder1In,
    input wire [`ATCB_TC2_W-1:0] coefOrder2In,
    input wire [`ATCB_CH_W-1:0] adcChannel,
    output wire trimActive,
    output wire [`ATCB_BYTE_W-1:0] offsetTrimOut,
    output wire [`ATCB_BYTE_W-1:0] gainTrimOut,
    output wire [`ATCB_TC0_W-1:0] gainOrder0Coefficient,
    output wire [`ATCB_TC1_W-1:0] gainOrder1Coefficient,
    output wire [`ATCB_TC2_W-1:0] gainOrder2Coefficient
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.

    wire wrPulse;
    wire rdCapture;
    wire [`ATCB_IDX_W-1:0] regIndex;
    wire lowLaneWrite;
    wire hitGainTrim;
    wire hitOffsetTrim;
    wire hitCoef;
    wire hitStatus;
    wire [`ATCB_BYTE_SEL_W-1:0] coefByteSel;
    wire [`ATCB_BYTE_W-1:0] coefByte;
    wire [`ATCB_IDX_W-1:0] coefIndexDelta;
    wire channelExcluded;
    wire channelShared;

    reg [`ATCB_BYTE_W-1:0] offsetTrim_reg;
    reg [`ATCB_BYTE_W-1:0] offsetTrim_next;
    reg [`ATCB_BYTE_W-1:0] gainTrim_reg;
    reg [`ATCB_BYTE_W-1:0] gainTrim_next;
    reg [`ATCB_TC0_W-1:0] order0_reg;
    reg [`ATCB_TC0_W-1:0] order0_next;
    reg [`ATCB_TC1_W-1:0] order1_reg;
    reg [`ATCB_TC1_W-1:0] order1_next;
    reg [`ATCB_TC2_W-1:0] order2_reg;
    reg [`ATCB_TC2_W-1:0] order2_next;
    reg coefValid_reg;
    reg coefValid_next;
    reg roWrite_reg;
    reg roWrite_next;
    reg [`ATCB_DAT_W-1:0] readData_reg;
    reg [`ATCB_DAT_W-1:0] readData_next;
    reg [`ATCB_BYTE_W-1:0] readByte;
    reg trimActive_reg;
    reg trimActive_next;
    reg [`ATCB_BYTE_W-1:0] offsetOut_reg;
    reg [`ATCB_BYTE_W-1:0] offsetOut_next;
    reg [`ATCB_BYTE_W-1:0] gainOut_reg;
    reg [`ATCB_BYTE_W-1:0] gainOut_next;

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake.

    atcb_wb_slave uWbSlave (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .cyc_i(cyc_i),
        .stb_i(stb_i),
        .we_i(we_i),
        .ack_o(ack_o),
        .wrPulse(wrPulse),
        .rdCapture(rdCapture)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Address decode; the two low address bits select nothing.

    assign regIndex = adr_i[`ATCB_ADR_W-1:2];
    assign lowLaneWrite = wrPulse & sel_i[0];

    assign hitGainTrim = (regIndex == `ATCB_IDX_GAIN_TRIM);
    assign hitOffsetTrim = (regIndex == `ATCB_IDX_OFFSET_TRIM);
    assign hitCoef = (regIndex >= `ATCB_IDX_TC0_LOW) && (regIndex <= `ATCB_IDX_TC2_HIGH);
    assign hitStatus = (regIndex == `ATCB_IDX_STATUS);

    assign coefIndexDelta = regIndex - `ATCB_IDX_TC0_LOW;
    assign coefByteSel = coefIndexDelta[`ATCB_BYTE_SEL_W-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Writable trims.

    always @* begin
        offsetTrim_next = offsetTrim_reg;
        if (lowLaneWrite && hitOffsetTrim) begin
            offsetTrim_next = dat_i[`ATCB_BYTE_W-1:0]; // [RULE1]
        end
    end

    always @* begin
        gainTrim_next = gainTrim_reg;
        if (lowLaneWrite && hitGainTrim) begin
            gainTrim_next = dat_i[`ATCB_BYTE_W-1:0]; // [RULE10]
        end
    end

    always @(posedge sys_clk) begin
        if (!rstn) begin
            offsetTrim_reg <= `ATCB_TRIM_RESET; // [RULE1]
        end else begin
            offsetTrim_reg <= offsetTrim_next;
        end
    end

    always @(posedge sys_clk) begin
        if (!rstn) begin
            gainTrim_reg <= `ATCB_TRIM_RESET; // [RULE10]
        end else begin
            gainTrim_reg <= gainTrim_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Coefficients come only from the trim load port; bus writes never reach them.

    always @* begin
        order0_next = order0_reg;
        if (coefLoad) begin
            order0_next = coefOrder0In;
        end
    end

    always @* begin
        order1_next = order1_reg;
        if (coefLoad) begin
            order1_next = coefOrder1In;
        end
    end

    always @* begin
        order2_next = order2_reg;
        if (coefLoad) begin
            order2_next = coefOrder2In;
        end
    end

    always @* begin
        coefValid_next = coefValid_reg;
        if (coefLoad) begin
            coefValid_next = 1'b1;
        end
    end

    always @(posedge sys_clk) begin
        if (!rstn) begin
            order0_reg <= `ATCB_TC0_RESET; // [RULE2]
            order1_reg <= `ATCB_TC1_RESET; // [RULE5]
            order2_reg <= `ATCB_TC2_RESET; // [RULE8]
        end else begin
            order0_reg <= order0_next; // [RULE11]
            order1_reg <= order1_next; // [RULE11]
            order2_reg <= order2_next; // [RULE11]
        end
    end

    always @(posedge sys_clk) begin
        if (!rstn) begin
            coefValid_reg <= 1'b0;
        end else begin
            coefValid_reg <= coefValid_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky flag for a write that hit a read-only coefficient byte.
    // Writing one to the flag clears it, but a new hit in the same cycle wins.

    always @* begin
        roWrite_next = roWrite_reg;
        if (lowLaneWrite && hitStatus && dat_i[`ATCB_STAT_RO_WRITE]) begin
            roWrite_next = 1'b0;
        end
        if (wrPulse && hitCoef) begin
            roWrite_next = 1'b1;
        end
    end

    always @(posedge sys_clk) begin
        if (!rstn) begin
            roWrite_reg <= 1'b0;
        end else begin
            roWrite_reg <= roWrite_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Coefficient byte packing.

    atcb_coef_pack uCoefPack (
        .order0(order0_reg),
        .order1(order1_reg),
        .order2(order2_reg),
        .byteSel(coefByteSel),
        .byteOut(coefByte)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read path; unmapped indexes answer with zero.

    always @* begin
        readByte = 8'h00;
        case (regIndex)
            `ATCB_IDX_GAIN_TRIM: begin
                readByte = gainTrim_reg; // [RULE10]
            end
            `ATCB_IDX_OFFSET_TRIM: begin
                readByte = offsetTrim_reg; // [RULE1]
            end
            `ATCB_IDX_TC0_LOW: begin
                readByte = coefByte; // [RULE2]
            end
            `ATCB_IDX_TC0_HIGH_TC1_LSB: begin
                readByte = coefByte; // [RULE3] [RULE4]
            end
            `ATCB_IDX_TC1_MID: begin
                readByte = coefByte; // [RULE5]
            end
            `ATCB_IDX_TC1_HIGH_TC2_LOW: begin
                readByte = coefByte; // [RULE6] [RULE7]
            end
            `ATCB_IDX_TC2_MID: begin
                readByte = coefByte; // [RULE8]
            end
            `ATCB_IDX_TC2_HIGH: begin
                readByte = coefByte; // [RULE9]
            end
            `ATCB_IDX_STATUS: begin
                readByte[`ATCB_STAT_COEF_VALID] = coefValid_reg;
                readByte[`ATCB_STAT_RO_WRITE] = roWrite_reg;
                readByte[`ATCB_STAT_TRIM_ACTIVE] = trimActive_reg;
            end
            default: begin
                readByte = 8'h00;
            end
        endcase
    end

    // Capturing read data touches no other state.
    always @* begin
        readData_next = readData_reg;
        if (rdCapture) begin
            readData_next = {24'h000000, readByte}; // [RULE11]
        end
    end

    always @(posedge sys_clk) begin
        if (!rstn) begin
            readData_reg <= 32'h00000000;
        end else begin
            readData_reg <= readData_next;
        end
    end

    assign dat_o = readData_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Trims reach the datapath only for channels outside the aux cell and GPIO set.

    assign channelExcluded = (adcChannel == `ATCB_CH_SEL_CELL)
        || ((adcChannel >= `ATCB_CH_GPIO_FIRST) && (adcChannel <= `ATCB_CH_GPIO_LAST));
    assign channelShared = ~channelExcluded;

    always @* begin
        trimActive_next = channelShared;
    end

    always @* begin
        offsetOut_next = 8'h00;
        if (channelShared) begin
            offsetOut_next = offsetTrim_reg; // [RULE1]
        end
    end

    always @* begin
        gainOut_next = 8'h00;
        if (channelShared) begin
            gainOut_next = gainTrim_reg; // [RULE10]
        end
    end

    always @(posedge sys_clk) begin
        if (!rstn) begin
            trimActive_reg <= 1'b0;
        end else begin
            trimActive_reg <= trimActive_next;
        end
    end

    always @(posedge sys_clk) begin
        if (!rstn) begin
            offsetOut_reg <= `ATCB_TRIM_RESET;
        end else begin
            offsetOut_reg <= offsetOut_next;
        end
    end

    always @(posedge sys_clk) begin
        if (!rstn) begin
            gainOut_reg <= `ATCB_TRIM_RESET;
        end else begin
            gainOut_reg <= gainOut_next;
        end
    end

    assign trimActive = trimActive_reg;
    assign offsetTrimOut = offsetOut_reg;
    assign gainTrimOut = gainOut_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Coefficients as the datapath sees them.

    assign gainOrder0Coefficient = order0_reg;
    assign gainOrder1Coefficient = order1_reg;
    assign gainOrder2Coefficient = order2_reg;

endmodule // atcb_top

`default_nettype wire

// >>> include/atcb_defines.vh
`ifndef ATCB_DEFINES_VH
`define ATCB_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Register indexes; the byte address on the bus is four times the index.
`define ATCB_IDX_W 7
`define ATCB_IDX_GAIN_TRIM 7'h4f
`define ATCB_IDX_OFFSET_TRIM 7'h50
`define ATCB_IDX_TC0_LOW 7'h51
`define ATCB_IDX_TC0_HIGH_TC1_LSB 7'h52
`define ATCB_IDX_TC1_MID 7'h53
`define ATCB_IDX_TC1_HIGH_TC2_LOW 7'h54
`define ATCB_IDX_TC2_MID 7'h55
`define ATCB_IDX_TC2_HIGH 7'h56
`define ATCB_IDX_STATUS 7'h60

////////////////////////////////////////////////////////////////////////////////
// Bus geometry.
`define ATCB_ADR_W 9
`define ATCB_DAT_W 32
`define ATCB_SEL_W 4
`define ATCB_BYTE_W 8
`define ATCB_COEF_BYTES 6
`define ATCB_BYTE_SEL_W 3

////////////////////////////////////////////////////////////////////////////////
// Coefficient widths and reset values.
`define ATCB_TC0_W 15
`define ATCB_TC1_W 14
`define ATCB_TC2_W 14
`define ATCB_TC0_RESET 15'h0000
`define ATCB_TC1_RESET 14'h0000
`define ATCB_TC2_RESET 14'h0000
`define ATCB_TRIM_RESET 8'h00

////////////////////////////////////////////////////////////////////////////////
// Status register fields.
`define ATCB_STAT_COEF_VALID 0
`define ATCB_STAT_RO_WRITE 1
`define ATCB_STAT_TRIM_ACTIVE 2

////////////////////////////////////////////////////////////////////////////////
// Channel codes of the inputs that the shared trims do not cover.
`define ATCB_CH_W 5
`define ATCB_CH_SEL_CELL 5'h01
`define ATCB_CH_GPIO_FIRST 5'h02
`define ATCB_CH_GPIO_LAST 5'h07

`endif

// >>> verilog/atcb_wb_slave.v
`timescale 1ns/1ps
`default_nettype none
`include "atcb_defines.vh"

module atcb_wb_slave (
    input wire sys_clk,
    input wire rstn,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    output wire ack_o,
    output wire wrPulse,
    output wire rdCapture
);

    reg ackReg;
    wire request;

    assign request = cyc_i & stb_i;

    ////////////////////////////////////////////////////////////////////////////
    // Ack follows a request by one cycle and drops in the next.
    always @(posedge sys_clk) begin
        if (!rstn) begin
            ackReg <= 1'b0;
        end else begin
            ackReg <= request & ~ackReg;
        end
    end

    assign ack_o = ackReg;
    // A write lands on the edge at which the master sees ack high.
    assign wrPulse = request & we_i & ackReg;
    // Read data is captured on the edge that raises ack.
    assign rdCapture = request & ~ackReg;

endmodule // atcb_wb_slave

`default_nettype wire

// >>> verilog/atcb_coef_pack.v
`timescale 1ns/1ps
`default_nettype none
`include "atcb_defines.vh"

module atcb_coef_pack (
    input wire [`ATCB_TC0_W-1:0] order0,
    input wire [`ATCB_TC1_W-1:0] order1,
    input wire [`ATCB_TC2_W-1:0] order2,
    input wire [`ATCB_BYTE_SEL_W-1:0] byteSel,
    output reg [`ATCB_BYTE_W-1:0] byteOut
);

    localparam integer PACK_W = `ATCB_COEF_BYTES * `ATCB_BYTE_W;
    localparam integer USED_W = `ATCB_TC0_W + `ATCB_TC1_W + `ATCB_TC2_W;

    wire [PACK_W-1:0] packWord;
    wire [`ATCB_BYTE_W-1:0] bytes [0:`ATCB_COEF_BYTES-1];

    // The three coefficients run back to back from the lowest byte upward.
    assign packWord = {{(PACK_W-USED_W){1'b0}}, order2, order1, order0}; // [RULE3] [RULE6] [RULE9]

    genvar b;
    generate
        for (b = 0; b < `ATCB_COEF_BYTES; b = b + 1) begin : gByte
            assign bytes[b] = packWord[b*`ATCB_BYTE_W +: `ATCB_BYTE_W];
        end
    endgenerate

    always @* begin
        byteOut = 8'h00;
        if (byteSel < 3'h6) begin
            byteOut = bytes[byteSel];
        end
    end

endmodule // atcb_coef_pack

`default_nettype wire

// >>> bench/atcb_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "atcb_defines.vh"

module atcb_top_chk (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [`ATCB_ADR_W-1:0] adr_i,
    input wire logic [`ATCB_DAT_W-1:0] dat_i,
    input wire logic [`ATCB_SEL_W-1:0] sel_i,
    input wire logic [`ATCB_DAT_W-1:0] dat_o,
    input wire logic ack_o,
    input wire logic coefLoad,
    input wire logic [`ATCB_TC0_W-1:0] coefOrder0In,
    input wire logic [`ATCB_TC1_W-1:0] coefOrder1In,
    input wire logic [`ATCB_TC2_W-1:0] coefOrder2In,
    input wire logic [`ATCB_CH_W-1:0] adcChannel,
    input wire logic trimActive,
    input wire logic [`ATCB_BYTE_W-1:0] offsetTrimOut,
    input wire logic [`ATCB_BYTE_W-1:0] gainTrimOut,
    input wire logic [`ATCB_TC0_W-1:0] gainOrder0Coefficient,
    input wire logic [`ATCB_TC1_W-1:0] gainOrder1Coefficient,
    input wire logic [`ATCB_TC2_W-1:0] gainOrder2Coefficient
);
    logic shared;
    logic coefRead;
    logic [7:0] coefByte;
    logic [47:0] coefAll;

    // The six coefficient bytes, low byte first, as the bank must present them.
    assign coefAll = {5'h00, gainOrder2Coefficient, gainOrder1Coefficient, gainOrder0Coefficient};
    assign shared = (adcChannel < `ATCB_CH_SEL_CELL) || (adcChannel > `ATCB_CH_GPIO_LAST);
    assign coefRead = (adr_i[8:2] >= `ATCB_IDX_TC0_LOW) && (adr_i[8:2] <= `ATCB_IDX_TC2_HIGH);
    assign coefByte = coefAll[8 * (adr_i[8:2] - `ATCB_IDX_TC0_LOW) +: 8];

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////////////
    chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing one cycle after a request");
    chk_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without a request");
    chk_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    chk_coef_readback: assert property (ack_o && !we_i && coefRead |-> dat_o[7:0] == $past(coefByte))
        else $error("coefficient byte read back wrong");
    chk_coef_load: assert property (coefLoad |=> coefAll[42:0] == $past({coefOrder2In, coefOrder1In, coefOrder0In}))
        else $error("coefficients not loaded");
    chk_coef_hold: assert property ($past(rstn) && !$past(coefLoad) |-> $stable(coefAll))
        else $error("coefficients changed without a load");
    chk_trim_gate: assert property ($past(rstn) |-> trimActive == $past(shared))
        else $error("trim active flag wrong for channel");
    chk_offset_gate: assert property (!trimActive |-> offsetTrimOut == 8'h00)
        else $error("offset trim applied to excluded channel");
    chk_gain_gate: assert property (!trimActive |-> gainTrimOut == 8'h00)
        else $error("gain trim applied to excluded channel");

    cov_coef_read: cover property (ack_o && !we_i && coefRead && dat_o[7:0] != 8'h00);
    cov_coef_write: cover property (ack_o && we_i && coefRead);
    cov_load: cover property (coefLoad);
    cov_excluded: cover property (!shared ##1 !trimActive);
endmodule // atcb_top_chk

bind atcb_top atcb_top_chk u_atcb_top_chk (.sys_clk, .rstn, .cyc_i, .stb_i, .we_i, .adr_i,
    .dat_i, .sel_i, .dat_o, .ack_o, .coefLoad, .coefOrder0In, .coefOrder1In, .coefOrder2In,
    .adcChannel, .trimActive, .offsetTrimOut, .gainTrimOut, .gainOrder0Coefficient,
    .gainOrder1Coefficient, .gainOrder2Coefficient);
`default_nettype wire

// >>> bench/atcb_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "atcb_defines.vh"

module tb;
    logic sys_clk;
    logic rstn;
    logic cyc_i;
    logic stb_i;
    logic we_i;
    logic [`ATCB_ADR_W-1:0] adr_i;
    logic [`ATCB_DAT_W-1:0] dat_i;
    logic [`ATCB_SEL_W-1:0] sel_i;
    wire [`ATCB_DAT_W-1:0] dat_o;
    wire ack_o;
    logic coefLoad;
    logic [`ATCB_TC0_W-1:0] coefOrder0In;
    logic [`ATCB_TC1_W-1:0] coefOrder1In;
    logic [`ATCB_TC2_W-1:0] coefOrder2In;
    logic [`ATCB_CH_W-1:0] adcChannel;
    wire trimActive;
    wire [7:0] offsetTrimOut;
    wire [7:0] gainTrimOut;
    wire [`ATCB_TC0_W-1:0] gainOrder0Coefficient;
    wire [`ATCB_TC1_W-1:0] gainOrder1Coefficient;
    wire [`ATCB_TC2_W-1:0] gainOrder2Coefficient;
    int nErrors;
    int totalChecks;
    logic [31:0] rngState;
    logic [7:0] expQ[$];
    logic [7:0] offsetVal;
    logic [7:0] gainVal;
    logic [47:0] coefBytes;
    logic shared;

    atcb_top u_atcb_top (.sys_clk, .rstn, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .sel_i,
        .dat_o, .ack_o, .coefLoad, .coefOrder0In, .coefOrder1In, .coefOrder2In, .adcChannel,
        .trimActive, .offsetTrimOut, .gainTrimOut, .gainOrder0Coefficient,
        .gainOrder1Coefficient, .gainOrder2Coefficient);

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    function automatic void stepRand();
        rngState = rngState ^ (rngState << 13);
        rngState = rngState ^ (rngState >> 17);
        rngState = rngState ^ (rngState << 5);
    endfunction

    task automatic check(input logic [47:0] seen, input logic [47:0] expected);
        totalChecks++;
        if (seen !== expected) begin
            nErrors++;
            $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, expected);
        end
    endtask

    task automatic summarize();
        if (nErrors == 0 && totalChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One classic cycle; a read notes its expected byte for the monitor.
    task automatic wb(input logic wr, input logic [6:0] idx, input logic [7:0] wdata,
                      input logic [3:0] sel, input logic [7:0] expData);
        if (!wr) begin
            expQ.push_back(expData);
        end
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= wr;
        adr_i <= {idx, 2'b00};
        dat_i <= {rngState[23:0], wdata};
        sel_i <= sel;
        do begin
            @(posedge sys_clk);
        end while (ack_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask

    always @(posedge sys_clk) begin
        if (rstn && ack_o === 1'b1 && we_i === 1'b0) begin
            check(48'(dat_o), expQ.size() > 0 ? 48'(expQ.pop_front()) : 48'hfff);
        end
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        nErrors++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rngState = 32'h0000002d;
        nErrors = 0;
        totalChecks = 0;
        rstn = 1'b0;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 9'h000;
        dat_i = 32'h00000000;
        sel_i = 4'h0;
        coefLoad = 1'b0;
        coefOrder0In = 15'h0000;
        coefOrder1In = 14'h0000;
        coefOrder2In = 14'h0000;
        adcChannel = 5'h10;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        for (int i = 'h4f; i <= 'h56; i++) begin
            wb(1'b0, i[6:0], 8'h00, 4'hf, 8'h00);
        end
        wb(1'b0, `ATCB_IDX_STATUS, 8'h00, 4'hf, 8'h04);
        wb(1'b1, 7'h70, 8'h5a, 4'h1, 8'h00);
        wb(1'b0, 7'h70, 8'h00, 4'hf, 8'h00);
        for (int k = 0; k < 4; k++) begin
            stepRand();
            offsetVal = rngState[7:0];
            gainVal = rngState[15:8];
            wb(1'b1, `ATCB_IDX_OFFSET_TRIM, offsetVal, 4'h1, 8'h00);
            wb(1'b1, `ATCB_IDX_GAIN_TRIM, gainVal, 4'h1, 8'h00);
            wb(1'b1, `ATCB_IDX_OFFSET_TRIM, ~offsetVal, 4'he, 8'h00);
            wb(1'b0, `ATCB_IDX_OFFSET_TRIM, 8'h00, 4'hf, offsetVal);
            wb(1'b0, `ATCB_IDX_GAIN_TRIM, 8'h00, 4'hf, gainVal);
        end
        for (int k = 0; k < 3; k++) begin
            stepRand();
            coefOrder0In <= rngState[14:0];
            coefOrder1In <= rngState[28:15];
            stepRand();
            coefOrder2In <= rngState[13:0];
            coefLoad <= 1'b1;
            @(posedge sys_clk);
            coefLoad <= 1'b0;
            coefBytes = {5'h00, coefOrder2In, coefOrder1In, coefOrder0In};
            @(posedge sys_clk);
            check(48'(gainOrder0Coefficient), 48'(coefOrder0In));
            check(48'(gainOrder1Coefficient), 48'(coefOrder1In));
            check(48'(gainOrder2Coefficient), 48'(coefOrder2In));
            for (int b = 0; b < 6; b++) begin
                wb(1'b0, 7'h51 + b[6:0], 8'h00, 4'hf, coefBytes[8*b+:8]);
                wb(1'b1, 7'h51 + b[6:0], ~coefBytes[8*b+:8], 4'h1, 8'h00);
                wb(1'b0, 7'h51 + b[6:0], 8'h00, 4'hf, coefBytes[8*b+:8]);
            end
        end
        wb(1'b0, `ATCB_IDX_STATUS, 8'h00, 4'hf, 8'h07);
        wb(1'b1, `ATCB_IDX_STATUS, 8'h02, 4'h1, 8'h00);
        wb(1'b0, `ATCB_IDX_STATUS, 8'h00, 4'hf, 8'h05);
        for (int ch = 0; ch < 32; ch++) begin
            adcChannel <= ch[4:0];
            @(posedge sys_clk);
            @(posedge sys_clk);
            shared = (ch < 1) || (ch > 7);
            check(48'(trimActive), 48'(shared));
            check(48'(offsetTrimOut), shared ? 48'(offsetVal) : 48'h0);
            check(48'(gainTrimOut), shared ? 48'(gainVal) : 48'h0);
        end
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        wb(1'b0, `ATCB_IDX_OFFSET_TRIM, 8'h00, 4'hf, 8'h00);
        wb(1'b0, `ATCB_IDX_TC1_MID, 8'h00, 4'hf, 8'h00);
        summarize();
    end
endmodule // tb
`default_nettype wire
